// [logic/event_flag_bank.sv]
// Purpose: sticky flag bank with per-source enable, write-one clear and mask
// Assumes: events are single-cycle or level strobes on the bus clock
// Notes: a set in the clearing cycle wins over the clear
`timescale 1ns/1ns
module event_flag_bank #(
  parameter int unsigned N = 5
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // flag bank
  flag_bank_if.bank fb
);
  logic [N-1:0] flags_q;
  logic [N-1:0] set_bits;

  // only enabled sources may set a flag
  assign set_bits = fb.evt & fb.en;

  // clear first, then set, so a fresh event is never lost
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      flags_q <= radio_ctrl_pkg::FLAGS_RST;
    end else begin
      flags_q <= (flags_q & ~fb.clr) | set_bits;
    end
  end

  // masking acts on the live flag state, not on the setting event
  assign fb.flags = flags_q;
  assign fb.pending = |(flags_q & ~fb.mask);

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  flag_set_a: assert property ((|set_bits) |=> ((flags_q & $past(set_bits)) == $past(set_bits)))
    else $error("enabled event did not set its flag");
  flag_clear_a: assert property ((|fb.clr) |=> ((flags_q & $past(fb.clr) & ~$past(set_bits)) == '0))
    else $error("written clear bit left its flag set");
  flag_only_set_a: assert property (((flags_q & ~$past(flags_q)) & ~$past(set_bits)) == '0)
    else $error("flag rose without an enabled event");
  set_beats_clear_a: assert property ((|(set_bits & fb.clr)) |=> ((flags_q & $past(set_bits)) != '0))
    else $error("event lost against a same-cycle clear");
endmodule

// [logic/flag_bank_if.sv]
// Purpose: carries one bank of sticky flags between the register block and the bank
// Assumes: one clock domain
// Notes: clr is already qualified by a bus write
`timescale 1ns/1ns
interface flag_bank_if #(parameter int unsigned N = 5);
  logic [N-1:0] evt;
  logic [N-1:0] en;
  logic [N-1:0] clr;
  logic [N-1:0] mask;
  logic [N-1:0] flags;
  logic pending;
  modport ctrl (output evt, output en, output clr, output mask, input flags, input pending);
  modport bank (input evt, input en, input clr, input mask, output flags, output pending);
endinterface

// [logic/radio_ctrl_irq_regs.sv]
// Purpose: register file, command strobes and interrupt/fault aggregation of the radio controller
// Assumes: AXI4-Lite slave, one write and one read outstanding, machines outside this block
// Notes: all outputs are flops; the interrupt follows the flags by one cycle
`timescale 1ns/1ns

// What this block does
// - five event flags set by enabled events
// - flag bits 0..4 read-only, reset zero
// - writing one clears event flag, zero keeps
// - event config holds enable, pulse, mask
// - enabled pulse to timer lasts as long as the event
// - masked events still set flags silently
// - unmasking a set flag raises interrupt
// - interrupt held while unmasked flag remains
// - five fault flags set by enabled faults
// - fault config enables 9..5, masks 4..0
// - masked faults set flag, no interrupt
// - writing one clears fault flag, zero keeps
// - load and send command bits start transmit
// - listen start and stop; zero does nothing
// - reinit bit resets all radio machines
// - status reports the three machine states
// - DMA word and pointer registers exposed
// - status ten bits: 2, 4, 4
// - faults never pulse the timer
// - packet length seven bits, up to 127
module radio_ctrl_irq_regs (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // axi4-lite write address and data
  input wire logic [31:0] i_awaddr,
  input wire logic [2:0] i_awprot,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  // axi4-lite write response
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  // axi4-lite read
  input wire logic [31:0] i_araddr,
  input wire logic [2:0] i_arprot,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  // radio machine states and events
  input wire logic [1:0] i_mode_state,
  input wire logic [3:0] i_tx_state,
  input wire logic [3:0] i_rx_state,
  input wire logic [radio_ctrl_pkg::N_SRC-1:0] i_event,
  input wire logic [radio_ctrl_pkg::N_SRC-1:0] i_fault,
  // dma side
  input wire logic i_tx_dma_word_we,
  input wire logic [31:0] i_tx_dma_word,
  input wire logic i_fetch_pointer_load,
  input wire logic i_fetch_pointer_step,
  input wire logic i_rx_dma_word_we,
  input wire logic [31:0] i_rx_dma_word,
  // commands and register values to the machines
  output logic [radio_ctrl_pkg::N_SRC-1:0] o_radio_command,
  output logic [31:0] o_tx_packet_start,
  output logic [radio_ctrl_pkg::LEN_W-1:0] o_tx_packet_length,
  output logic [31:0] o_tx_dma_word,
  output logic [31:0] o_tx_fetch_pointer,
  // timer pulses and processor interrupt
  output logic [radio_ctrl_pkg::N_SRC-1:0] o_timer_pulse,
  output logic o_irq
);
  localparam int unsigned NR = 13;

  logic awready_q;
  logic wready_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic arready_q;
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [31:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic aw_full_q;
  logic w_full_q;
  logic do_wr;
  logic [NR-1:0] wsel;
  logic [NR-1:0] rsel;
  logic rd_take;
  logic [radio_ctrl_pkg::N_SRC-1:0] command_q;
  logic [31:0] start_q;
  logic [radio_ctrl_pkg::LEN_W-1:0] length_q;
  logic [radio_ctrl_pkg::EVT_CFG_W-1:0] evt_cfg_q;
  logic [radio_ctrl_pkg::FLT_CFG_W-1:0] flt_cfg_q;
  logic [31:0] tx_dma_word_q;
  logic [31:0] fetch_pointer_q;
  logic [31:0] rx_dma_word_q;
  logic [radio_ctrl_pkg::N_SRC-1:0] pulse_q;
  logic irq_q;
  logic [radio_ctrl_pkg::N_SRC-1:0] evt_pulse_en;

  flag_bank_if #(.N(radio_ctrl_pkg::N_SRC)) evt_if ();
  flag_bank_if #(.N(radio_ctrl_pkg::N_SRC)) flt_if ();

  // one-hot register select; misaligned or unknown addresses select nothing
  function automatic logic [NR-1:0] reg_decode(input logic [31:0] a);
    logic [NR-1:0] s;
    s = '0;
    s[0] = (a == radio_ctrl_pkg::OFF_RADIO_COMMAND);
    s[1] = (a == radio_ctrl_pkg::OFF_MACHINE_STATE);
    s[2] = (a == radio_ctrl_pkg::OFF_TX_PACKET_START);
    s[3] = (a == radio_ctrl_pkg::OFF_TX_PACKET_LENGTH);
    s[4] = (a == radio_ctrl_pkg::OFF_EVENT_FLAGS);
    s[5] = (a == radio_ctrl_pkg::OFF_EVENT_CONFIG);
    s[6] = (a == radio_ctrl_pkg::OFF_EVENT_FLAG_CLEAR);
    s[7] = (a == radio_ctrl_pkg::OFF_FAULT_FLAGS);
    s[8] = (a == radio_ctrl_pkg::OFF_FAULT_CONFIG);
    s[9] = (a == radio_ctrl_pkg::OFF_FAULT_FLAG_CLEAR);
    s[10] = (a == radio_ctrl_pkg::OFF_TX_DMA_WORD);
    s[11] = (a == radio_ctrl_pkg::OFF_TX_DMA_FETCH_POINTER);
    s[12] = (a == radio_ctrl_pkg::OFF_RX_DMA_WORD);
    return s;
  endfunction

  // byte-lane merge of a write into an existing word
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_w, input logic [31:0] new_w,
                                              input logic [3:0] be);
    logic [31:0] r;
    r = old_w;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = new_w[8*b +: 8];
      end
    end
    return r;
  endfunction

  assign wsel = reg_decode(awaddr_q);
  assign rsel = reg_decode(i_araddr);
  assign do_wr = aw_full_q & w_full_q & ~bvalid_q;
  assign rd_take = i_arvalid & arready_q;

  // write address and data are taken in either order and held until the response is taken
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      awaddr_q <= radio_ctrl_pkg::WORD_RST;
      wdata_q <= radio_ctrl_pkg::WORD_RST;
      wstrb_q <= 4'h0;
    end else begin
      if (i_awvalid && awready_q) begin
        awaddr_q <= i_awaddr;
        aw_full_q <= 1'b1;
        awready_q <= 1'b0;
      end
      if (i_wvalid && wready_q) begin
        wdata_q <= i_wdata;
        wstrb_q <= i_wstrb;
        w_full_q <= 1'b1;
        wready_q <= 1'b0;
      end
      if (bvalid_q && i_bready) begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
    end
  end

  // write response one cycle after both halves are held; unknown address answers slverr
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      bvalid_q <= 1'b0;
      bresp_q <= radio_ctrl_pkg::RESP_OKAY;
    end else if (do_wr) begin
      bvalid_q <= 1'b1;
      bresp_q <= (|wsel) ? radio_ctrl_pkg::RESP_OKAY : radio_ctrl_pkg::RESP_SLVERR;
    end else if (bvalid_q && i_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // command strobes last one cycle; a zero bit does nothing
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      command_q <= '0;
    end else if (do_wr && wsel[0] && wstrb_q[0]) begin
      command_q <= wdata_q[radio_ctrl_pkg::N_SRC-1:0];
    end else begin
      command_q <= '0;
    end
  end

  // software-owned words; the block never alters start or length
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      start_q <= radio_ctrl_pkg::WORD_RST;
      length_q <= radio_ctrl_pkg::LEN_RST;
    end else if (do_wr) begin
      if (wsel[2]) begin
        start_q <= merge_bytes(start_q, wdata_q, wstrb_q);
      end
      if (wsel[3] && wstrb_q[0]) begin
        length_q <= wdata_q[radio_ctrl_pkg::LEN_W-1:0];
      end
    end
  end

  // configuration registers, only the low bits of the word exist
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      evt_cfg_q <= radio_ctrl_pkg::EVT_CFG_RST;
      flt_cfg_q <= radio_ctrl_pkg::FLT_CFG_RST;
    end else if (do_wr) begin
      if (wsel[5]) begin
        evt_cfg_q <= (radio_ctrl_pkg::EVT_CFG_W)'(merge_bytes({17'h0, evt_cfg_q}, wdata_q, wstrb_q));
      end
      if (wsel[8]) begin
        flt_cfg_q <= (radio_ctrl_pkg::FLT_CFG_W)'(merge_bytes({22'h0, flt_cfg_q}, wdata_q, wstrb_q));
      end
    end
  end

  // dma-owned words; the machines' load and step beat a software write
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      tx_dma_word_q <= radio_ctrl_pkg::WORD_RST;
      fetch_pointer_q <= radio_ctrl_pkg::WORD_RST;
      rx_dma_word_q <= radio_ctrl_pkg::WORD_RST;
    end else begin
      if (i_tx_dma_word_we) begin
        tx_dma_word_q <= i_tx_dma_word;
      end
      if (i_rx_dma_word_we) begin
        rx_dma_word_q <= i_rx_dma_word;
      end
      if (i_fetch_pointer_load) begin
        fetch_pointer_q <= start_q;
      end else if (i_fetch_pointer_step) begin
        fetch_pointer_q <= fetch_pointer_q + 32'h0000_0004;
      end else if (do_wr && wsel[11]) begin
        fetch_pointer_q <= merge_bytes(fetch_pointer_q, wdata_q, wstrb_q);
      end
    end
  end

  // flag banks: clear strobes come from a lane-0 write of the clear registers
  assign evt_if.evt = i_event;
  assign evt_if.en = evt_cfg_q[radio_ctrl_pkg::EVT_EN_LSB +: radio_ctrl_pkg::N_SRC];
  assign evt_if.mask = evt_cfg_q[radio_ctrl_pkg::EVT_MASK_LSB +: radio_ctrl_pkg::N_SRC];
  assign evt_if.clr = (do_wr && wsel[6] && wstrb_q[0]) ? wdata_q[radio_ctrl_pkg::N_SRC-1:0] : '0;
  assign flt_if.evt = i_fault;
  assign flt_if.en = flt_cfg_q[radio_ctrl_pkg::FLT_EN_LSB +: radio_ctrl_pkg::N_SRC];
  assign flt_if.mask = flt_cfg_q[radio_ctrl_pkg::FLT_MASK_LSB +: radio_ctrl_pkg::N_SRC];
  assign flt_if.clr = (do_wr && wsel[9] && wstrb_q[0]) ? wdata_q[radio_ctrl_pkg::N_SRC-1:0] : '0;

  event_flag_bank #(.N(radio_ctrl_pkg::N_SRC)) u_event_bank (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .fb(evt_if.bank)
  );

  event_flag_bank #(.N(radio_ctrl_pkg::N_SRC)) u_fault_bank (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .fb(flt_if.bank)
  );

  // timer pulses follow the event itself, independent of flag enable; faults have no path here
  assign evt_pulse_en = evt_cfg_q[radio_ctrl_pkg::EVT_PULSE_LSB +: radio_ctrl_pkg::N_SRC];
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      pulse_q <= '0;
    end else begin
      pulse_q <= i_event & evt_pulse_en;
    end
  end

  // one level interrupt, registered so the core sees a clean flop
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= evt_if.pending | flt_if.pending;
    end
  end

  // read mux; write-only registers and the unused upper bits read as zero
  always_comb begin
    rdata_d = '0;
    if (rsel[1]) begin
      rdata_d[radio_ctrl_pkg::ST_MODE_LSB +: 2] = i_mode_state;
      rdata_d[radio_ctrl_pkg::ST_TX_LSB +: 4] = i_tx_state;
      rdata_d[radio_ctrl_pkg::ST_RX_LSB +: 4] = i_rx_state;
    end
    if (rsel[2]) begin
      rdata_d = start_q;
    end
    if (rsel[3]) begin
      rdata_d[radio_ctrl_pkg::LEN_W-1:0] = length_q;
    end
    if (rsel[4]) begin
      rdata_d[radio_ctrl_pkg::N_SRC-1:0] = evt_if.flags;
    end
    if (rsel[5]) begin
      rdata_d[radio_ctrl_pkg::EVT_CFG_W-1:0] = evt_cfg_q;
    end
    if (rsel[7]) begin
      rdata_d[radio_ctrl_pkg::N_SRC-1:0] = flt_if.flags;
    end
    if (rsel[8]) begin
      rdata_d[radio_ctrl_pkg::FLT_CFG_W-1:0] = flt_cfg_q;
    end
    if (rsel[10]) begin
      rdata_d = tx_dma_word_q;
    end
    if (rsel[11]) begin
      rdata_d = fetch_pointer_q;
    end
    if (rsel[12]) begin
      rdata_d = rx_dma_word_q;
    end
  end

  // read channel: answer one cycle after the address is taken
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rresp_q <= radio_ctrl_pkg::RESP_OKAY;
      rdata_q <= radio_ctrl_pkg::WORD_RST;
    end else if (rd_take) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= rdata_d;
      rresp_q <= (|rsel) ? radio_ctrl_pkg::RESP_OKAY : radio_ctrl_pkg::RESP_SLVERR;
    end else if (rvalid_q && i_rready) begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  // outputs straight from flops
  assign o_awready = awready_q;
  assign o_wready = wready_q;
  assign o_bvalid = bvalid_q;
  assign o_bresp = bresp_q;
  assign o_arready = arready_q;
  assign o_rvalid = rvalid_q;
  assign o_rresp = rresp_q;
  assign o_rdata = rdata_q;
  assign o_radio_command = command_q;
  assign o_tx_packet_start = start_q;
  assign o_tx_packet_length = length_q;
  assign o_tx_dma_word = tx_dma_word_q;
  assign o_tx_fetch_pointer = fetch_pointer_q;
  assign o_timer_pulse = pulse_q;
  assign o_irq = irq_q;

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  irq_raise_a: assert property ((evt_if.pending || flt_if.pending) |=> o_irq)
    else $error("unmasked flag did not raise the interrupt");
  irq_drop_a: assert property ((!evt_if.pending && !flt_if.pending) |=> !o_irq)
    else $error("interrupt high with no unmasked flag");
  unmask_irq_a: assert property ((do_wr && wsel[5] && wstrb_q[0] && (|(evt_if.flags & ~wdata_q[4:0])))
                                 |=> ##1 o_irq)
    else $error("unmasking a set flag left the interrupt low");
  pulse_width_a: assert property ((i_event[0] && evt_pulse_en[0] ##1 !i_event[0])
                                  |-> o_timer_pulse[0] ##1 !o_timer_pulse[0])
    else $error("timer pulse not one cycle long");
  cmd_strobe_a: assert property ((do_wr && wsel[0] && wstrb_q[0] && wdata_q[4])
                                 |=> o_radio_command[4] ##1 !o_radio_command[4])
    else $error("reinit command not a single strobe");
  status_read_a: assert property ((rd_take && rsel[1]) |=> (o_rvalid && o_rdata[31:10] == 22'h0
                                  && o_rdata[9:8] == $past(i_mode_state)))
    else $error("status read returned wrong state");
  bresp_hold_a: assert property ((o_bvalid && !i_bready) |=> (o_bvalid && $stable(o_bresp)))
    else $error("write response dropped before it was taken");

  masked_set_c: cover property (do_wr && wsel[5] ##[1:20] (|(evt_if.flags & evt_if.mask)));
  unmask_c: cover property ((|(evt_if.flags & evt_if.mask)) ##[1:20] o_irq);
  fault_irq_c: cover property (flt_if.pending ##1 o_irq);
  set_clear_c: cover property (|(evt_if.clr & i_event & evt_if.en));
endmodule

// [logic/radio_ctrl_pkg.sv]
// Purpose: shared constants for the radio controller register and event block
// Assumes: 32-bit AXI4-Lite register bus, one aligned word per register
// Notes: offsets are full byte addresses
package radio_ctrl_pkg;
  // source counts and widths
  localparam int unsigned N_SRC = 5;
  localparam int unsigned LEN_W = 7;
  localparam int unsigned STATE_W = 10;
  localparam int unsigned EVT_CFG_W = 15;
  localparam int unsigned FLT_CFG_W = 10;

  // register byte addresses
  localparam logic [31:0] OFF_RADIO_COMMAND = 32'h4000_0000;
  localparam logic [31:0] OFF_MACHINE_STATE = 32'h4000_0004;
  localparam logic [31:0] OFF_TX_PACKET_START = 32'h4000_0008;
  localparam logic [31:0] OFF_TX_PACKET_LENGTH = 32'h4000_000c;
  localparam logic [31:0] OFF_EVENT_FLAGS = 32'h4000_0010;
  localparam logic [31:0] OFF_EVENT_CONFIG = 32'h4000_0014;
  localparam logic [31:0] OFF_EVENT_FLAG_CLEAR = 32'h4000_0018;
  localparam logic [31:0] OFF_FAULT_FLAGS = 32'h4000_001c;
  localparam logic [31:0] OFF_FAULT_CONFIG = 32'h4000_0020;
  localparam logic [31:0] OFF_FAULT_FLAG_CLEAR = 32'h4000_0024;
  localparam logic [31:0] OFF_TX_DMA_WORD = 32'h4000_0028;
  localparam logic [31:0] OFF_TX_DMA_FETCH_POINTER = 32'h4000_002c;
  localparam logic [31:0] OFF_RX_DMA_WORD = 32'h4000_0030;

  // command bits
  localparam int unsigned CMD_TX_LOAD = 0;
  localparam int unsigned CMD_TX_SEND = 1;
  localparam int unsigned CMD_RX_START = 2;
  localparam int unsigned CMD_RX_STOP = 3;
  localparam int unsigned CMD_REINIT = 4;

  // event_config groups, fault_config groups
  localparam int unsigned EVT_EN_LSB = 10;
  localparam int unsigned EVT_PULSE_LSB = 5;
  localparam int unsigned EVT_MASK_LSB = 0;
  localparam int unsigned FLT_EN_LSB = 5;
  localparam int unsigned FLT_MASK_LSB = 0;

  // machine_state fields
  localparam int unsigned ST_MODE_LSB = 8;
  localparam int unsigned ST_TX_LSB = 4;
  localparam int unsigned ST_RX_LSB = 0;

  // reset values
  localparam logic [EVT_CFG_W-1:0] EVT_CFG_RST = 15'h0000;
  localparam logic [FLT_CFG_W-1:0] FLT_CFG_RST = 10'h000;
  localparam logic [N_SRC-1:0] FLAGS_RST = 5'h00;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;
  localparam logic [LEN_W-1:0] LEN_RST = 7'h00;

  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// [test/radio_ctrl_irq_regs_tb.sv]
// Purpose: self-checking bench for the radio register and event block
// Assumes: the bench is the AXI4-Lite master; machines come from radio_machine_model
// Notes: flags, config and irq are predicted by a small model kept here
`timescale 1ns/1ns
module radio_ctrl_irq_regs_tb;
  logic i_ref_clk = 1'h0;
  logic i_rst = 1'h1;
  logic [31:0] i_awaddr = 32'h0, i_wdata = 32'h0, i_araddr = 32'h0, o_rdata;
  logic i_awvalid = 1'h0, i_wvalid = 1'h0, i_bready = 1'h0, i_arvalid = 1'h0, i_rready = 1'h0;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_irq;
  logic [1:0] o_bresp, o_rresp, i_mode_state;
  logic [3:0] i_tx_state, i_rx_state;
  logic [4:0] i_event, i_fault, ev_req = 5'h00, flt_req = 5'h00, o_radio_command, o_timer_pulse;
  logic i_tx_dma_word_we = 1'h0, i_fetch_pointer_load = 1'h0, i_fetch_pointer_step = 1'h0;
  logic i_rx_dma_word_we = 1'h0;
  logic [31:0] i_tx_dma_word = 32'h0, i_rx_dma_word = 32'h0, o_tx_packet_start, o_tx_dma_word;
  logic [31:0] o_tx_fetch_pointer, d, v, st;
  logic [6:0] o_tx_packet_length;
  logic [1:0] r;
  logic [4:0] een, pen, emk, fen, fmk, ef = 5'h00, ff = 5'h00;
  logic [4:0] cv[6] = '{5'h01, 5'h02, 5'h04, 5'h08, 5'h10, 5'h00};
  logic [9:0] sv[6] = '{10'h110, 10'h120, 10'h221, 10'h020, 10'h000, 10'h000};
  int fail_count = 0, total_checks = 0, cyc = 0, seed = 32'h69aa8c4d;
  int ch[5], ph[5], cp[5];
  radio_ctrl_irq_regs radio_ctrl_irq_regs_i (.i_ref_clk, .i_rst, .i_awaddr, .i_awprot(3'h0), .i_awvalid,
    .o_awready, .i_wdata, .i_wstrb(4'hf), .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready,
    .i_araddr, .i_arprot(3'h0), .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready,
    .i_mode_state, .i_tx_state, .i_rx_state, .i_event, .i_fault, .i_tx_dma_word_we, .i_tx_dma_word,
    .i_fetch_pointer_load, .i_fetch_pointer_step, .i_rx_dma_word_we, .i_rx_dma_word, .o_radio_command,
    .o_tx_packet_start, .o_tx_packet_length, .o_tx_dma_word, .o_tx_fetch_pointer, .o_timer_pulse, .o_irq);
  radio_machine_model radio_machine_model_i (.i_ref_clk, .i_rst, .i_command(o_radio_command),
    .i_ev_req(ev_req), .i_flt_req(flt_req), .o_event(i_event), .o_fault(i_fault),
    .o_mode(i_mode_state), .o_tx(i_tx_state), .o_rx(i_rx_state));
  // clock
  always #50 i_ref_clk = ~i_ref_clk;
  // count command and pulse cycles per bit; a hang ends the run
  always @(posedge i_ref_clk) begin
    cyc <= cyc + 1;
    for (int i = 0; i < 5; i++) begin
      ch[i] <= ch[i] + int'(o_radio_command[i]);
      ph[i] <= ph[i] + int'(o_timer_pulse[i]);
    end
    if (cyc == 20000) begin
      fail_count++;
      finish_test();
    end
  end
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  // write: address and data offered together, each dropped once taken
  task automatic wr(input logic [31:0] a, input logic [31:0] x);
    @(posedge i_ref_clk);
    i_awaddr <= a;
    i_wdata <= x;
    i_awvalid <= 1'h1;
    i_wvalid <= 1'h1;
    i_bready <= 1'h1;
    forever begin
      @(posedge i_ref_clk);
      if (o_awready === 1'h1) i_awvalid <= 1'h0;
      if (o_wready === 1'h1) i_wvalid <= 1'h0;
      if (o_bvalid === 1'h1) break;
    end
    r = o_bresp;
    i_bready <= 1'h0;
  endtask
  task automatic rd(input logic [31:0] a);
    @(posedge i_ref_clk);
    i_araddr <= a;
    i_arvalid <= 1'h1;
    i_rready <= 1'h1;
    forever begin
      @(posedge i_ref_clk);
      if (o_arready === 1'h1) i_arvalid <= 1'h0;
      if (o_rvalid === 1'h1) break;
    end
    d = o_rdata;
    r = o_rresp;
    i_rready <= 1'h0;
  endtask
  task automatic cfg(input logic [4:0] a, b, c, e, f);
    een = a;
    pen = b;
    emk = c;
    fen = e;
    fmk = f;
    wr(radio_ctrl_pkg::OFF_EVENT_CONFIG, {17'h0, een, pen, emk});
    wr(radio_ctrl_pkg::OFF_FAULT_CONFIG, {22'h0, fen, fmk});
    rd(radio_ctrl_pkg::OFF_EVENT_CONFIG);
    chk("event_config", d, {17'h0, een, pen, emk});
    rd(radio_ctrl_pkg::OFF_FAULT_CONFIG);
    chk("fault_config", d, {22'h0, fen, fmk});
  endtask
  task automatic check_flags();
    rd(radio_ctrl_pkg::OFF_EVENT_FLAGS);
    chk("event_flags", d, {27'h0, ef});
    rd(radio_ctrl_pkg::OFF_FAULT_FLAGS);
    chk("fault_flags", d, {27'h0, ff});
    chk("irq", {31'h0, o_irq}, {31'h0, |((ef & ~emk) | (ff & ~fmk))});
  endtask
  // one-cycle strobes; faults must never reach the timer pulses
  task automatic fire(input logic [4:0] e, input logic [4:0] f);
    int p[5];
    p = ph;
    @(posedge i_ref_clk);
    ev_req <= e;
    flt_req <= f;
    @(posedge i_ref_clk);
    ev_req <= 5'h00;
    flt_req <= 5'h00;
    repeat (4) @(posedge i_ref_clk);
    ef = ef | (e & een);
    ff = ff | (f & fen);
    for (int i = 0; i < 5; i++) chk("pulse", ph[i] - p[i], {31'h0, e[i] & pen[i]});
    check_flags();
  endtask
  task automatic clr(input logic [4:0] e, input logic [4:0] f);
    wr(radio_ctrl_pkg::OFF_EVENT_FLAG_CLEAR, {27'h0, e});
    wr(radio_ctrl_pkg::OFF_FAULT_FLAG_CLEAR, {27'h0, f});
    ef = ef & ~e;
    ff = ff & ~f;
    check_flags();
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (2) @(posedge i_ref_clk);
    i_rst <= 1'h0;
    cfg(5'h00, 5'h00, 5'h00, 5'h00, 5'h00);
    check_flags();
    wr(32'h4000_0034, 32'hffff_ffff);
    chk("bresp", r, radio_ctrl_pkg::RESP_SLVERR);
    rd(32'h4000_0034);
    chk("rresp", r, radio_ctrl_pkg::RESP_SLVERR);
    $display("test reset and map done");
    // masked sources set flags silently, unmasking raises irq, irq holds until all cleared
    cfg(5'h1f, 5'h1f, 5'h1f, 5'h1f, 5'h1f);
    fire(5'h1f, 5'h1f);
    cfg(5'h1f, 5'h00, 5'h00, 5'h1f, 5'h00);
    clr(5'h1f, 5'h00);
    wr(radio_ctrl_pkg::OFF_EVENT_FLAGS, 32'h1f);
    clr(5'h00, 5'h15);
    clr(5'h00, 5'h0a);
    $display("test mask and clear done");
    repeat (10) begin
      cfg(5'($random(seed)), 5'($random(seed)), 5'($random(seed)), 5'($random(seed)), 5'($random(seed)));
      fire(5'($random(seed)), 5'($random(seed)));
      clr(5'($random(seed)), 5'($random(seed)));
    end
    $display("test random events done");
    // event only in the clearing cycle keeps its flag
    cfg(5'h1f, 5'h00, 5'h00, 5'h00, 5'h00);
    fork
      wr(radio_ctrl_pkg::OFF_EVENT_FLAG_CLEAR, 32'h1f);
      begin
        @(posedge i_ref_clk);
        ev_req <= 5'h01;
        @(posedge i_ref_clk);
        ev_req <= 5'h00;
      end
    join
    repeat (2) @(posedge i_ref_clk);
    ef = 5'h01;
    check_flags();
    $display("test set beats clear done");
    foreach (cv[i]) begin
      cp = ch;
      wr(radio_ctrl_pkg::OFF_RADIO_COMMAND, {27'h0, cv[i]});
      repeat (2) @(posedge i_ref_clk);
      for (int j = 0; j < 5; j++) chk("command", ch[j] - cp[j], {31'h0, cv[i][j]});
      rd(radio_ctrl_pkg::OFF_MACHINE_STATE);
      chk("state", d, {22'h0, sv[i]});
    end
    $display("test commands done");
    // packet setup by software, then the dma side moves words and the pointer
    st = $random(seed) & 32'hffff_fffc;
    v = $random(seed);
    wr(radio_ctrl_pkg::OFF_TX_PACKET_START, st);
    wr(radio_ctrl_pkg::OFF_TX_PACKET_LENGTH, 32'hff);
    chk("length", {25'h0, o_tx_packet_length}, 32'h7f);
    chk("start", o_tx_packet_start, st);
    i_tx_dma_word <= v;
    i_rx_dma_word <= ~v;
    i_tx_dma_word_we <= 1'h1;
    i_rx_dma_word_we <= 1'h1;
    i_fetch_pointer_load <= 1'h1;
    @(posedge i_ref_clk);
    i_tx_dma_word_we <= 1'h0;
    i_rx_dma_word_we <= 1'h0;
    i_fetch_pointer_load <= 1'h0;
    i_fetch_pointer_step <= 1'h1;
    @(posedge i_ref_clk);
    i_fetch_pointer_step <= 1'h0;
    rd(radio_ctrl_pkg::OFF_TX_DMA_WORD);
    chk("tx_dma_word", d, v);
    rd(radio_ctrl_pkg::OFF_RX_DMA_WORD);
    chk("rx_dma_word", d, ~v);
    rd(radio_ctrl_pkg::OFF_TX_DMA_FETCH_POINTER);
    chk("fetch_pointer", d, st + 32'h4);
    chk("fetch_out", o_tx_fetch_pointer, st + 32'h4);
    chk("dma_out", o_tx_dma_word, v);
    $display("test packet and dma done");
    finish_test();
  end
endmodule

// [test/radio_machine_model.sv]
// Purpose: far-side model of the radio machines feeding the register block
// Assumes: commands arrive as one-cycle pulses from the block
// Notes: state codes are arbitrary picks; strobes follow bench requests
`timescale 1ns/1ns
module radio_machine_model (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // bench requests and block commands
  input wire logic [4:0] i_command,
  input wire logic [4:0] i_ev_req,
  input wire logic [4:0] i_flt_req,
  // strobes and states to the block
  output logic [4:0] o_event,
  output logic [4:0] o_fault,
  output logic [1:0] o_mode,
  output logic [3:0] o_tx,
  output logic [3:0] o_rx
);
  // strobes are the requests one cycle late, so a level request stays a level
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_event <= 5'h00;
      o_fault <= 5'h00;
    end else begin
      o_event <= i_ev_req;
      o_fault <= i_flt_req;
    end
  end
  // reinit wins over the rest so a stuck machine always recovers
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      {o_mode, o_tx, o_rx} <= 10'h000;
    end else if (i_command[4]) begin
      {o_mode, o_tx, o_rx} <= 10'h000;
    end else begin
      if (i_command[0]) {o_mode, o_tx} <= 6'h11;
      if (i_command[1]) o_tx <= 4'h2;
      if (i_command[2]) {o_mode, o_rx} <= 6'h21;
      if (i_command[3]) {o_mode, o_rx} <= 6'h00;
    end
  end
endmodule
